// ===== common/adc_queue_if.sv
// Purpose: Carrier between sequencer and its pending queue
// Assumes: One clock domain
// Notes: Valid/ready on both sides
`timescale 1ns/1ps
interface adc_queue_if #(
  parameter int width = 32
);
  logic in_valid;                // Fill side valid
  logic in_ready;                // Fill side ready
  logic [width-1:0] in_data;     // Fill side word
  logic out_valid;               // Drain side valid
  logic out_ready;               // Drain side ready
  logic [width-1:0] out_data;    // Drain side word

  modport fill
  (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
  modport queue
  (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
endinterface : adc_queue_if

// ===== common/adc_seq_pkg.sv
// Purpose: Shared constants for the conversion sequencer
// Assumes: System clock of 100 MHz
// Notes: Times in ns, cycle counts derived from them
package adc_seq_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int clk_period_ns = 10;               // System clock period
  localparam int convert_time_ns = 1000;           // Conversion latency
  localparam int min_start_ns = 500;               // Least start spacing
  localparam int valid_low_ns = 100;               // Ready-low duration
  // Latency and low time round down, spacing rounds up; all at least 1
  localparam int convert_cycles = (convert_time_ns / clk_period_ns < 1) ? 1 : convert_time_ns / clk_period_ns;
  localparam int min_start_cycles = ((min_start_ns + clk_period_ns - 1) / clk_period_ns < 1) ? 1 :
    (min_start_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int valid_low_cycles = (valid_low_ns / clk_period_ns < 1) ? 1 : valid_low_ns / clk_period_ns;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] reg_ctrl = 8'h00;         // Control: bit0 signed coding
  localparam logic [7:0] reg_offset = 8'h04;       // Input offset
  localparam logic [7:0] reg_span = 8'h08;         // Full-scale span
  localparam logic [7:0] reg_status = 8'h0c;       // Status
  localparam logic [7:0] reg_count = 8'h10;        // Accepted and rejected counts
  localparam logic [7:0] reg_result = 8'h14;       // Last result code
  localparam int ctrl_signed_bit = 0;              // Signed coding field
  localparam logic [31:0] offset_reset = 32'h0000_0000;  // Offset default 0
  localparam logic [31:0] span_reset = 32'h0001_0000;    // Span default 1.0 (Q16.16)
  localparam int span_frac_bits = 16;              // Span fraction bits

  // ----------------------------------------
  // Pending-result queue
  // ----------------------------------------
  localparam int queue_depth = 8;                  // FIFO entries

endpackage : adc_seq_pkg

// ===== design/adc_conversion_sequencer.sv
// Purpose: Timing and coding for a clocked analog-to-digital converter
// Assumes: Inputs synchronous to hclk; sample is a signed 32-bit value
// Notes: Registers over AHB-Lite; pending conversions queued in a FIFO
// Summary of operation
// - Each trigger rising edge starts a conversion when spacing is met and the queue has room
// - Input sampled at the starting edge
// - Code updates one latency after start
// - Ready drops at update, rises after delay
// - Overlapping starts allowed after minimum spacing
// - Too-early trigger edges start nothing but are counted as rejected
// - Code width parameter from 1 to 32
// - Offset binary default, optional two's complement
// - Subtract offset, scale by full-scale span
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int code_bits = 12,
  parameter int convert_cyc = adc_seq_pkg::convert_cycles,
  parameter int min_start_cyc = adc_seq_pkg::min_start_cycles,
  parameter int valid_low_cyc = adc_seq_pkg::valid_low_cycles
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic trigger,
  input wire logic signed [31:0] analog_in,
  output logic [code_bits-1:0] data_out,
  output logic data_valid,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import adc_seq_pkg::*;

  // ----------------------------------------
  // Build-time checks
  // ----------------------------------------
  // Width range check
  if (code_bits < 1 || code_bits > 32)
  begin : g_bad_width
    $error("code width out of range");
  end

  localparam int tw = 32;                       // Timer width
  localparam int ew = 32 + tw;                  // Queue entry: sample and due time

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic signed_mode;                            // Two's complement select
  logic signed [31:0] in_offset;                // Offset removed before scaling
  logic [31:0] span;                            // Full-scale span, Q16.16
  logic [15:0] accepted_count;                  // Accepted starts
  logic [15:0] rejected_count;                  // Ignored starts
  logic [31:0] last_result;                     // Last presented code
  logic bus_pend;                               // Data phase pending
  logic bus_wr;                                 // Pending is a write
  logic [7:0] bus_addr;                         // Pending address

  // ----------------------------------------
  // Timers and trigger edge
  // ----------------------------------------
  logic [tw-1:0] now;                           // Cycle time, advancing only while ce is high
  logic [tw-1:0] since_start;                   // Cycles since last accepted start
  logic any_start;                              // A start has been accepted
  logic trig_d;                                 // Trigger last cycle
  logic [15:0] low_cnt;                         // Ready-low countdown

  wire trig_rise = ce && trigger && !trig_d;
  wire spacing_ok = !any_start || (since_start > tw'(min_start_cyc));
  // Relies on spacing below latency so the queue stays shallow
  adc_queue_if #(.width(ew)) qi ();
  // Accept start on edge if spaced and queue has room
  wire accept = trig_rise && spacing_ok && qi.in_ready;
  wire reject = trig_rise && !accept;

  // Sample captured with its due time
  assign qi.in_valid = accept;
  assign qi.in_data = {analog_in, now + tw'(convert_cyc)};

  wire [31:0] head_sample = qi.out_data[ew-1:tw];
  wire [tw-1:0] head_due = qi.out_data[tw-1:0];
  // Head presented when its due time arrives
  wire due = qi.out_valid && (head_due == now);
  assign qi.out_ready = due;

  adc_fifo #(.width(ew), .depth(queue_depth)) u_fifo
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .q(qi)
  );

  // ----------------------------------------
  // Coding
  // ----------------------------------------
  // Remove offset, then scale by span
  wire signed [32:0] diff = 33'(signed'(head_sample)) - 33'(in_offset);
  wire signed [65:0] scaled = 66'(diff) * 66'(signed'({1'b0, span}));
  wire signed [49:0] scaled_int = scaled[65:16];
  localparam logic signed [49:0] max_s = 50'((64'sd1 <<< (code_bits - 1)) - 1);
  localparam logic signed [49:0] min_s = -50'((64'sd1 <<< (code_bits - 1)));
  wire signed [49:0] clipped = (scaled_int > max_s) ? max_s : ((scaled_int < min_s) ? min_s : scaled_int);
  // Offset binary flips the sign bit
  wire [code_bits-1:0] twos_code = clipped[code_bits-1:0];
  wire [code_bits-1:0] sign_flip = code_bits'(1) << (code_bits - 1);
  wire [code_bits-1:0] next_code = signed_mode ? twos_code : (twos_code ^ sign_flip);

  // Time base and spacing counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      now <= '0;
      since_start <= '0;
      any_start <= 1'b0;
      trig_d <= 1'b0;
    end
    else if (ce)
    begin
      now <= now + 1'b1;
      trig_d <= trigger;
      if (accept)
      begin
        since_start <= tw'(1);
        any_start <= 1'b1;
      end
      else if (since_start != '1)
        since_start <= since_start + 1'b1;
    end
  end

  // ----------------------------------------
  // Result presentation
  // ----------------------------------------
  // Ready low on update, high after delay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_out <= '0;
      data_valid <= 1'b1;
      low_cnt <= '0;
    end
    else if (ce)
    begin
      if (due)
      begin
        data_out <= next_code;
        data_valid <= 1'b0;
        low_cnt <= 16'(valid_low_cyc);
      end
      else if (low_cnt > 16'd1)
        low_cnt <= low_cnt - 1'b1;
      else if (low_cnt == 16'd1)
      begin
        low_cnt <= '0;
        data_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  wire addr_ph = hsel && hready && htrans[1];
  wire wr_now = ce && bus_pend && bus_wr;

  // Bus phase tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_pend <= 1'b0;
      bus_wr <= 1'b0;
      bus_addr <= '0;
    end
    else if (ce)
    begin
      bus_pend <= addr_ph;
      if (addr_ph)
      begin
        bus_wr <= hwrite;
        bus_addr <= haddr[7:0];
      end
    end
  end

  // Register writes and counters
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      signed_mode <= 1'b0;
      in_offset <= offset_reset;
      span <= span_reset;
      accepted_count <= '0;
      rejected_count <= '0;
      last_result <= '0;
    end
    else if (ce)
    begin
      if (wr_now && bus_addr == reg_ctrl)
        signed_mode <= hwdata[ctrl_signed_bit];
      if (wr_now && bus_addr == reg_offset)
        in_offset <= hwdata;
      if (wr_now && bus_addr == reg_span)
        span <= hwdata;
      if (accept)
        accepted_count <= accepted_count + 1'b1;
      if (reject)
        rejected_count <= rejected_count + 1'b1;
      if (due)
        last_result <= 32'(next_code);
    end
  end

  // Read data mux
  wire [31:0] next_rdata =
    (bus_addr == reg_ctrl) ? {31'h0, signed_mode} :
    (bus_addr == reg_offset) ? in_offset :
    (bus_addr == reg_span) ? span :
    (bus_addr == reg_status) ? {29'h0, !qi.in_ready, qi.out_valid, data_valid} :
    (bus_addr == reg_count) ? {rejected_count, accepted_count} :
    (bus_addr == reg_result) ? last_result : 32'h0;

  // Read data register, one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      hresp <= 1'b0;
      if (addr_ph && !hwrite)
        hreadyout <= 1'b0;
      else if (bus_pend && !hreadyout)
      begin
        hreadyout <= 1'b1;
        hrdata <= next_rdata;
      end
      else
        hreadyout <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  spacing_a: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |-> !any_start || since_start > tw'(min_start_cyc))
    else $error("start accepted too soon");
  early_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (trig_rise && any_start && since_start <= tw'(min_start_cyc)) |-> !accept)
    else $error("early trigger accepted");
  edge_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |-> trig_rise)
    else $error("start without trigger edge");
  sample_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |-> qi.in_data[ew-1:tw] == analog_in)
    else $error("sample not taken at edge");
  latency_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    accept |-> ##convert_cyc due)
    else $error("result presented off time");
  valid_drop_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    due |=> !data_valid && data_out == $past(next_code))
    else $error("ready did not drop with update");
  ordered_a: assert property (@(posedge hclk) disable iff (!hresetn)
    qi.out_valid |-> (head_due - now) <= tw'(convert_cyc))
    else $error("pending result out of order");
  mode_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
    qi.out_valid |-> next_code[code_bits-1] == (signed_mode ? clipped[49] : !clipped[49]))
    else $error("coding sign bit wrong");

endmodule : adc_conversion_sequencer

// ===== design/adc_fifo.sv
// Purpose: Flip-flop FIFO holding pending conversions
// Assumes: Depth is a power of two
// Notes: Honest full and empty, no bypass
`timescale 1ns/1ps
module adc_fifo #(
  parameter int width = 32,
  parameter int depth = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  adc_queue_if.queue q
);

  localparam int aw = $clog2(depth);

  logic [width-1:0] mem [depth];   // Storage
  logic [aw:0] wr_ptr;             // Write pointer with wrap bit
  logic [aw:0] rd_ptr;             // Read pointer with wrap bit

  // ----------------------------------------
  // Flags and handshakes
  // ----------------------------------------
  wire full = (wr_ptr[aw] != rd_ptr[aw]) && (wr_ptr[aw-1:0] == rd_ptr[aw-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = ce && q.in_valid && !full;
  wire pop = ce && q.out_ready && !empty;
  assign q.in_ready = !full;
  assign q.out_valid = !empty;
  assign q.out_data = mem[rd_ptr[aw-1:0]];

  // Pointer update
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge hclk)
  begin
    if (push)
      mem[wr_ptr[aw-1:0]] <= q.in_data;
  end

endmodule : adc_fifo

// ===== dv/adc_conversion_sequencer_test.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Short counts 60/4/2 cycles, 12-bit code
// Notes: Random samples from a fixed seed
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
  import adc_seq_pkg::*;
  localparam int lat = 60;     // Conversion latency
  localparam int gap_min = 4;  // Least start spacing
  localparam int low_cyc = 2;  // Ready-low cycles
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic trigger;
  logic signed [31:0] analog_in;
  logic [11:0] data_out;
  logic data_valid;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int seed = 32'h17bfd2f7;
  int failures = 0;
  int cmp_count = 0;
  int acc = 0;          // Expected accepted starts
  int rej = 0;          // Expected refused starts
  logic sgn = 1'b0;     // Mirror of signed coding
  longint off = 0;      // Mirror of offset
  longint span = 65536; // Mirror of span
  logic [11:0] exp_q[$];
  int exp_at[$];
  logic [31:0] rd;
  int at;
  logic [31:0] dflt[9] = '{0, 0, 32'h10000, 1, 0, 0, 0, 0, 0};
  logic [31:0] spans[3] = '{32'h10000, 32'h8000, 32'h20000};

  always #5 hclk = ~hclk;

  adc_conversion_sequencer #(.code_bits(12), .convert_cyc(lat), .min_start_cyc(gap_min), .valid_low_cyc(low_cyc))
  DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .trigger(trigger), .analog_in(analog_in),
    .data_out(data_out), .data_valid(data_valid), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

  adc_source_model src (.hclk(hclk), .hresetn(hresetn), .data_out(data_out),
    .data_valid(data_valid), .trigger(trigger), .analog_in(analog_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    cmp_count++;
    if (seen !== want)
    begin
      failures++;
      $display("Error %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // One single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    // Select stays up between transfers; IDLE marks the gap
    check(hresp, 1'b0, "bus response");
  endtask : bus

  // Expected code: offset, span, clip, coding
  function automatic logic [11:0] code_of(input longint a);
    longint v;
    v = ((a - off) * span) >>> 16;
    if (v > 2047)
      v = 2047;
    if (v < -2048)
      v = -2048;
    return sgn ? v[11:0] : v[11:0] ^ 12'h800;
  endfunction : code_of

  task automatic cfg(input logic s, input longint o, input longint p);
    sgn = s;
    off = o;
    span = p;
    bus(1'b1, {24'h0, reg_ctrl}, {31'h0, s}, rd);
    bus(1'b1, {24'h0, reg_offset}, o[31:0], rd);
    bus(1'b1, {24'h0, reg_span}, p[31:0], rd);
  endtask : cfg

  task automatic shot(input int v, input int gap, input bit ok);
    src.fire(v, gap, at);
    if (ok)
    begin
      exp_q.push_back(code_of(v));
      exp_at.push_back(at);
      acc++;
    end
    else
      rej++;
  endtask : shot

  // Wait for results, then compare code, timing and ready pulse
  task automatic drain;
    int n = 0;
    while (src.got.size() < exp_q.size() && n < 400)
    begin
      @(posedge hclk);
      n++;
    end
    repeat (lat) @(posedge hclk);
    check(src.got.size(), exp_q.size(), "result count");
    while (exp_q.size() > 0 && src.got.size() > 0)
    begin
      check(src.got.pop_front(), exp_q.pop_front(), "code");
      check(src.got_cyc.pop_front() - exp_at.pop_front(), lat + 1, "latency");
      check(src.low_len.pop_front(), low_cyc, "ready low");
    end
    exp_q.delete();
    exp_at.delete();
    src.got.delete();
    src.got_cyc.delete();
    src.low_len.delete();
  endtask : drain

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(data_valid, 1'b1, "ready idle");
    check(data_out, 12'h0, "code reset");
    // Unmapped write ignored, then defaults
    bus(1'b1, 32'h20, 32'hffff_ffff, rd);
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, 4 * i, 32'h0, rd);
      check(rd, dflt[i], "reg reset");
    end
    for (int m = 0; m < 6; m++)
    begin
      if (m > 0)
        cfg(m[0], $random(seed) % 400, spans[m % 3]);
      for (int k = 0; k < 4; k++)
        shot($random(seed) % 3000, 6, 1'b1);
      drain();
    end
    // overlap at five, refusal at four
    shot(100, 5, 1'b1);
    shot(-200, 4, 1'b1);
    shot(300, 6, 1'b0);
    shot(-400, 6, 1'b1);
    drain();
    shot(500, 6, 1'b1);
    ce <= 1'b0;
    repeat (7) @(posedge hclk);
    ce <= 1'b1;
    exp_at[0] += 7;
    drain();
    // eight pending, then a full queue refuses
    for (int k = 0; k < 10; k++)
      shot($random(seed) % 3000, 6, k < queue_depth);
    drain();
    bus(1'b0, {24'h0, reg_count}, 32'h0, rd);
    check(rd, {rej[15:0], acc[15:0]}, "counts");
    stop_test();
  end

  // Watchdog on a hung run
  initial
  begin
    #200000;
    failures++;
    $display("Error %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : adc_conversion_sequencer_test

// ===== dv/adc_source_model.sv
// Purpose: Analog source and code consumer beside the sequencer
// Assumes: Driven just after rising hclk edges
// Notes: Input is inverted once its sample edge has passed
`timescale 1ns/1ps
module adc_source_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [11:0] data_out,
  input wire logic data_valid,
  output logic trigger,
  output logic signed [31:0] analog_in
);
  int cyc = 0;          // Free-running edge count
  int lows = 0;         // Current ready-low run
  logic [11:0] got[$];  // Codes seen at each update
  int got_cyc[$];       // Edge at which each code was seen
  int low_len[$];       // Length of each ready-low run

  // Idle source at time zero
  initial
  begin
    trigger = 1'b0;
    analog_in = 32'sh0;
  end

  // Take the code when ready drops, time each low run
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (hresetn && !data_valid)
      lows <= lows + 1;
    if (hresetn && $fell(data_valid))
    begin
      got.push_back(data_out);
      got_cyc.push_back(cyc);
    end
    if (hresetn && $rose(data_valid))
    begin
      low_len.push_back(lows);
      lows <= 0;
    end
  end

  // One trigger pulse; next rise comes gap edges later
  task automatic fire(input int v, input int gap, output int at);
    trigger <= 1'b1;
    analog_in <= v;
    @(posedge hclk);
    at = cyc;
    trigger <= 1'b0;
    // Sample no longer held, so show its inverse
    analog_in <= ~v;
    repeat (gap - 1) @(posedge hclk);
  endtask : fire
endmodule : adc_source_model
